// *** rtl/pzts_pkg.sv ***
// shared constants and carriers for the pipelined zero-turnaround sram port
package pzts_pkg;
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam int WORD_W = LANE_W * LANES;
  localparam int ADDR_W = 18;
  localparam int BEAT_W = 2;
  localparam int FIFO_DEPTH = 16;
  localparam logic MODE_INTERLEAVED = 1'h1;
  localparam logic RW_READ = 1'h1;
  localparam logic [BEAT_W-1:0] BEAT_FIRST = 2'h0;
  localparam logic [BEAT_W-1:0] BEAT_STEP = 2'h1;

  typedef enum logic {
    PZTS_IDLE = 1'h0,
    PZTS_BURST = 1'h1
  } pzts_state_t;

  // one pipeline slot: an issued beat on its way to the data bus
  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] be_n;
  } pzts_slot_t;

  // one fifo word: array read result plus whether it is to be driven
  typedef struct packed {
    logic rd;
    logic [WORD_W-1:0] data;
  } pzts_rd_t;
endpackage : pzts_pkg

// *** rtl/pzts_port.sv ***
// burst sram port core with read-data fifo
// Function
// - address captured on selected load with clock enabled
// - low address bits seed the burst counter
// - each nine-bit lane has own write enable
// - lane enables ignored when read sampled
// - write data stored two cycles after command
// - enable a..d govern lanes a..d respectively
// - clock enable high freezes everything
// - load read/write fixes direction of burst
// - data bus activity two cycles after command
// - all synchronous logic on rising edge
// - any false select with load deselects
// - bus high impedance two cycles after deselect
// - high select mirrors low selects, inverted
// - output enable high forces data pins off
// - selected load refreshes address and control
// - advance steps burst counter of running burst
// - advance ignores address and read/write inputs
// - burst order high interleaved, low linear
// - four beats per externally supplied address
// - deselect lets issued transfers complete

module pzts_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [PW:0] wr_q, wr_d, rd_q, rd_d;
  logic push, pop;
  logic full, empty;

  // pointers carry one extra wrap bit to tell full from empty
  assign full = (wr_q[PW] != rd_q[PW]) && (wr_q[PW-1:0] == rd_q[PW-1:0]);
  assign empty = (wr_q == rd_q);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem_q[rd_q[PW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    if (push) begin
      wr_d = wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = rd_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // storage has no reset; only the pointers do
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q[PW-1:0]] <= in_data_i;
    end
  end
endmodule : pzts_fifo

module pzts_port #(
  parameter int FIFO_DEPTH = pzts_pkg::FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [pzts_pkg::ADDR_W-3:0] upper_address_inputs_i,
  input wire logic addr_bit_one_i,
  input wire logic addr_bit_zero_i,
  input wire logic advance_not_load_i,
  input wire logic read_write_i,
  input wire logic [pzts_pkg::LANES-1:0] lane_write_enables_n_i,
  input wire logic chip_select_n_i,
  input wire logic select_secondary_n_i,
  input wire logic select_secondary_i,
  input wire logic clock_enable_n_i,
  input wire logic output_enable_n_i,
  input wire logic burst_order_i,
  input wire logic [pzts_pkg::WORD_W-1:0] data_i,
  output logic [pzts_pkg::WORD_W-1:0] data_o,
  output logic data_oe_o
);
  localparam int FW = $bits(pzts_pkg::pzts_rd_t);

  logic [pzts_pkg::WORD_W-1:0] mem_q [2**pzts_pkg::ADDR_W];

  pzts_pkg::pzts_state_t state_q, state_d;
  logic write_q, write_d;
  logic [pzts_pkg::ADDR_W-3:0] base_q, base_d;
  logic [pzts_pkg::BEAT_W-1:0] start_q, start_d, cnt_q, cnt_d, next_cnt;
  pzts_pkg::pzts_slot_t st1_q, st1_d, st2_q, st2_d;
  logic [pzts_pkg::WORD_W-1:0] out_q, out_d;
  logic out_rd_q, out_rd_d;
  logic selected, run;
  logic [pzts_pkg::WORD_W-1:0] rd_word, wr_word;
  pzts_pkg::pzts_rd_t push_word, pop_word;
  logic [FW-1:0] pop_bits;
  logic fifo_in_ready, fifo_out_valid;
  logic sel_primary, sel_second_low, sel_second_high;
  logic load_write;
  logic mem_we;
  logic [pzts_pkg::ADDR_W-1:0] mem_addr;
  logic [pzts_pkg::WORD_W-1:0] mem_wdata;

  // byte-lane merge: lane i is taken from new only when its enable is low
  function automatic logic [pzts_pkg::WORD_W-1:0] lane_merge(
    input logic [pzts_pkg::WORD_W-1:0] old_w,
    input logic [pzts_pkg::WORD_W-1:0] new_w,
    input logic [pzts_pkg::LANES-1:0] be_n
  );
    logic [pzts_pkg::WORD_W-1:0] res;
    res = old_w;
    for (int i = 0; i < pzts_pkg::LANES; i++) begin
      if (!be_n[i]) begin
        res[i*pzts_pkg::LANE_W +: pzts_pkg::LANE_W] = new_w[i*pzts_pkg::LANE_W +: pzts_pkg::LANE_W];
      end
    end
    return res;
  endfunction : lane_merge

  // low address bits of a beat
  function automatic logic [pzts_pkg::BEAT_W-1:0] beat_bits(
    input logic [pzts_pkg::BEAT_W-1:0] start,
    input logic [pzts_pkg::BEAT_W-1:0] cnt,
    input logic mode
  );
    if (mode == pzts_pkg::MODE_INTERLEAVED) begin
      return start ^ cnt;
    end
    return start + cnt;
  endfunction : beat_bits

  // direction decode of the read/write pin
  function automatic logic rw_is_write(
    input logic rw
  );
    return (rw != pzts_pkg::RW_READ);
  endfunction : rw_is_write

  // each select alone; any false one with a load is a deselect
  assign sel_primary = !chip_select_n_i;
  assign sel_second_low = !select_secondary_n_i;
  assign sel_second_high = select_secondary_i;
  assign selected = sel_primary && sel_second_low && sel_second_high;
  assign load_write = rw_is_write(read_write_i);
  // a high clock enable freezes every register as if the edge never came
  assign run = !clock_enable_n_i;
  assign next_cnt = cnt_q + pzts_pkg::BEAT_STEP;

  // command stage and two-deep pipeline
  always_comb begin
    state_d = state_q;
    write_d = write_q;
    base_d = base_q;
    start_d = start_q;
    cnt_d = cnt_q;
    st1_d = st1_q;
    st2_d = st2_q;
    if (run) begin
      st2_d = st1_q;
      st1_d = '0;
      if (!advance_not_load_i) begin
        if (selected) begin
          state_d = pzts_pkg::PZTS_BURST;
          write_d = load_write;
          base_d = upper_address_inputs_i;
          start_d = {addr_bit_one_i, addr_bit_zero_i};
          cnt_d = pzts_pkg::BEAT_FIRST;
          st1_d.valid = 1'b1;
          st1_d.write = load_write;
          st1_d.addr = {upper_address_inputs_i, addr_bit_one_i, addr_bit_zero_i};
          st1_d.be_n = load_write ? lane_write_enables_n_i : '1;
        end else begin
          state_d = pzts_pkg::PZTS_IDLE;
        end
      end else begin
        unique case (state_q)
          pzts_pkg::PZTS_IDLE: begin
            // an advance with no burst running issues nothing
          end
          pzts_pkg::PZTS_BURST: begin
            cnt_d = next_cnt;
            st1_d.valid = 1'b1;
            st1_d.write = write_q;
            st1_d.addr = {base_q, beat_bits(start_q, next_cnt, burst_order_i)};
            st1_d.be_n = write_q ? lane_write_enables_n_i : '1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= pzts_pkg::PZTS_IDLE;
      write_q <= 1'b0;
      base_q <= '0;
      start_q <= '0;
      cnt_q <= '0;
      st1_q <= '0;
      st2_q <= '0;
    end else begin
      state_q <= state_d;
      write_q <= write_d;
      base_q <= base_d;
      start_q <= start_d;
      cnt_q <= cnt_d;
      st1_q <= st1_d;
      st2_q <= st2_d;
    end
  end

  // array read one cycle after command, forwarding the write landing now;
  // without it a read right behind a write to the same word sees old data
  always_comb begin
    rd_word = mem_q[st1_q.addr];
    if (st2_q.valid && st2_q.write && (st2_q.addr == st1_q.addr)) begin
      rd_word = lane_merge(rd_word, data_i, st2_q.be_n);
    end
    wr_word = lane_merge(mem_q[st2_q.addr], data_i, st2_q.be_n);
    push_word.rd = st1_q.valid && !st1_q.write;
    push_word.data = rd_word;
  end

  // array write port: enabled lanes of the beat issued two edges ago
  always_comb begin
    mem_we = run && st2_q.valid && st2_q.write;
    mem_addr = st2_q.addr;
    mem_wdata = wr_word;
  end

  // write data sampled two edges after its command
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      mem_q[mem_addr] <= mem_wdata;
    end
  end

  // pushed and popped on every enabled edge, so it holds at most one word
  pzts_fifo #(
    .W(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_rd_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(run && fifo_in_ready),
    .in_ready_o(fifo_in_ready),
    .in_data_i(push_word),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(run),
    .out_data_o(pop_bits)
  );

  assign pop_word = pop_bits;

  // output register: loaded on the second edge after a read beat
  always_comb begin
    out_d = out_q;
    out_rd_d = out_rd_q;
    if (run) begin
      out_rd_d = fifo_out_valid && pop_word.rd;
      if (fifo_out_valid && pop_word.rd) begin
        out_d = pop_word.data;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      out_q <= '0;
      out_rd_q <= 1'b0;
    end else begin
      out_q <= out_d;
      out_rd_q <= out_rd_d;
    end
  end

  // pins are driven only for a registered read beat with output enable low
  assign data_o = out_q;
  assign data_oe_o = out_rd_q && !output_enable_n_i;
endmodule : pzts_port

// *** tb/pzts_port_assertions.sv ***
// pin-level assertion checker for the burst sram port
module pzts_port_assertions #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic advance_not_load_i,
  input wire logic read_write_i,
  input wire logic chip_select_n_i,
  input wire logic select_secondary_n_i,
  input wire logic select_secondary_i,
  input wire logic clock_enable_n_i,
  input wire logic output_enable_n_i,
  input wire logic [pzts_pkg::WORD_W-1:0] data_o,
  input wire logic data_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic sel = !chip_select_n_i && !select_secondary_n_i && select_secondary_i;
  wire logic ld = !clock_enable_n_i && !advance_not_load_i;
  sequence rd; ld && sel && read_write_i; endsequence
  sequence wr; ld && sel && !read_write_i; endsequence
  sequence ds; ld && !sel; endsequence
  sequence adv; !clock_enable_n_i && advance_not_load_i; endsequence
  sequence run2; !clock_enable_n_i [*2] ##1 !output_enable_n_i; endsequence
  a_read_drive: assert property (rd ##1 run2 |-> data_oe_o)
    else $error("read beat not driven");
  a_write_quiet: assert property (wr ##1 run2 |-> !data_oe_o)
    else $error("write beat drove the bus");
  a_desel_quiet: assert property (ds ##1 run2 |-> !data_oe_o)
    else $error("bus driven after deselect");
  a_desel_drain: assert property (rd ##1 ds ##1 !clock_enable_n_i ##1 !output_enable_n_i |-> data_oe_o)
    else $error("pending read dropped");
  a_burst_beats: assert property (rd ##1 adv [*3] ##1 run2 |-> data_oe_o)
    else $error("fourth burst beat missing");
  a_oe_gate: assert property (output_enable_n_i |-> !data_oe_o)
    else $error("driving with output enable off");
  a_stall_data: assert property (clock_enable_n_i |=> $stable(data_o))
    else $error("read data moved during stall");
  a_stall_drive: assert property (clock_enable_n_i && !output_enable_n_i |=> output_enable_n_i || $stable(data_oe_o))
    else $error("drive flag moved during stall");
endmodule : pzts_port_assertions

bind pzts_port pzts_port_assertions #(.FIFO_DEPTH(FIFO_DEPTH)) i_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .advance_not_load_i(advance_not_load_i), .read_write_i(read_write_i), .chip_select_n_i(chip_select_n_i),
  .select_secondary_n_i(select_secondary_n_i), .select_secondary_i(select_secondary_i),
  .clock_enable_n_i(clock_enable_n_i), .output_enable_n_i(output_enable_n_i), .data_o(data_o),
  .data_oe_o(data_oe_o));

// *** tb/pzts_ctrl_model.sv ***
// write-data side of the memory controller
module pzts_ctrl_model (
  input wire logic clk_i,
  input wire logic cke_n_i,
  input wire logic wr_i,
  input wire logic [pzts_pkg::WORD_W-1:0] wd_i,
  output logic [pzts_pkg::WORD_W-1:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] v_q = 2'h0;
  logic [pzts_pkg::WORD_W-1:0] d_q[2];
  initial data_o = '0;
  always @(posedge clk_i) if (!cke_n_i) begin
    v_q <= {v_q[0], wr_i};
    d_q <= '{wd_i, d_q[0]};
  end
  // data two enabled edges after the beat, else a changing pattern
  always @(negedge clk_i) data_o <= v_q[1] ? d_q[1] : ~data_o;
endmodule : pzts_ctrl_model

// *** tb/pzts_port_test.sv ***
// self-checking bench for the burst sram port
module pzts_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int W = pzts_pkg::WORD_W;
  logic clk_i = 0, rst_n = 0, adv = 0, rw = 1, cs_n = 1, s2_n = 1, s2 = 0, cke_n = 0, oe_n = 0, mode = 0;
  logic wr = 0, nv = 0, act = 0, brw = 0, oe = 0, mo = 0, doe;
  logic [17:0] ad = 18'h0, base = 18'h0, ea;
  logic [1:0] cnt = 2'h0;
  logic [3:0] be_n = 4'hF;
  logic [W-1:0] wd = '0, nd = '0, din, dout, ed[3];
  logic [W-1:0] mem[int];
  logic [2:0] ev = 3'h0;
  int err_count = 0, tests_run = 0;
  always #2 clk_i = ~clk_i;
  pzts_port #(.FIFO_DEPTH(16)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n), .upper_address_inputs_i(ad[17:2]),
    .addr_bit_one_i(ad[1]), .addr_bit_zero_i(ad[0]), .advance_not_load_i(adv), .read_write_i(rw),
    .lane_write_enables_n_i(be_n), .chip_select_n_i(cs_n), .select_secondary_n_i(s2_n),
    .select_secondary_i(s2), .clock_enable_n_i(cke_n), .output_enable_n_i(oe_n), .burst_order_i(mode),
    .data_i(din), .data_o(dout), .data_oe_o(doe));
  pzts_ctrl_model i_ctrl (.clk_i(clk_i), .cke_n_i(cke_n), .wr_i(wr), .wd_i(wd), .data_o(din));
  task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic results;
    if (err_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  // k: 0 load, 1 advance, 2 deselect through select a[1:0], 3 stall
  task automatic op(input int k, input logic r, input logic [17:0] a, input logic [3:0] b, input logic [W-1:0] d);
    logic g;
    @(negedge clk_i);
    {adv, rw, cke_n, cs_n, s2_n, s2, oe_n, mode, ad, be_n, wd} <= {k == 1, r, k == 3, k == 2 && a[1:0] == 2'h0,
      k == 2 && a[1:0] == 2'h1, !(k == 2 && a[1:0] == 2'h2), oe, mo, a, b, d};
    if (k == 0) {act, brw, base, cnt} = {1'b1, r, a, 2'h0};
    else if (k == 1 && act) cnt++;
    else if (k == 2) act = 0;
    g = k == 0 || (k == 1 && act);
    ea = {base[17:2], mo ? base[1:0] ^ cnt : base[1:0] + cnt};
    if (g && !brw) for (int i = 0; i < 4; i++) if (!b[i]) mem[ea][i*9 +: 9] = d[i*9 +: 9];
    wr = g && !brw;
    nv = g && brw;
    nd = mem.exists(ea) ? mem[ea] : 'x;
  endtask : op
  always @(posedge clk_i) begin
    if (!rst_n) ev <= 3'h0;
    else if (!cke_n) begin
      ev <= {ev[1:0], nv};
      ed <= '{nd, ed[0], ed[1]};
    end
  end
  always @(negedge clk_i) if (rst_n) begin
    check({35'h0, doe}, {35'h0, ev[2] && !oe_n});
    if (ev[2] && !oe_n) check(dout, ed[2]);
  end
  initial begin
    repeat (4) @(negedge clk_i);
    rst_n <= 1'b1;
    op(0, 0, 18'h10, 4'h0, 36'h123456789);
    op(0, 1, 18'h10, 4'h0, 36'h0);
    for (int i = 0; i < 5; i++) begin
      op(0, 0, 18'h10, 4'hF ^ (4'h1 << i), 36'hABCDEF012 + 36'(i));
      op(0, 1, 18'h10, 4'h0, 36'h0);
    end
    for (int j = 0; j < 2; j++) begin
      mo = j[0];
      op(2, 0, 18'h0, 4'h0, 36'h0);
      op(0, 0, 18'h41, j ? 4'h6 : 4'h0, {4{9'(j + 3)}});
      for (int k = 1; k < 4; k++) op(1, 1, 18'h3, j ? 4'h6 : 4'h0, {4{9'(k * 37 + j)}});
      op(0, 1, 18'h42, 4'h0, 36'h0);
      for (int k = 0; k < 4; k++) op(1, 0, 18'h0, 4'h0, 36'h0);
      op(0, 1, 18'h41, 4'h0, 36'h0);
      op(3, 0, 18'h0, 4'h0, 36'h0);
      op(3, 1, 18'h2, 4'h0, 36'h0);
      op(1, 0, 18'h0, 4'h0, 36'h0);
    end
    for (int j = 0; j < 3; j++) begin
      op(0, 1, 18'h42, 4'h0, 36'h0);
      op(2, 0, 18'(j), 4'h0, 36'h0);
      op(1, 1, 18'h0, 4'h0, 36'h0);
      op(1, 1, 18'h0, 4'h0, 36'h0);
    end
    oe = 1;
    op(0, 1, 18'h10, 4'h0, 36'h0);
    op(2, 0, 18'h0, 4'h0, 36'h0);
    op(2, 0, 18'h0, 4'h0, 36'h0);
    oe = 0;
    repeat (3) op(2, 0, 18'h0, 4'h0, 36'h0);
    results();
  end
  // about 60 cycles expected, so 1000 cycles means a hang
  initial begin
    #4000;
    err_count++;
    results();
  end
endmodule : pzts_port_test
